/* pcr_bank.sv */
// Configuration register bank of the on-chip clock loop, Wishbone slave.
// Notes on behaviour
// R1: Fraction is 16-bit value over 65535, two bytes.
// R2: Fractional divider used only when mode bit set.
// R3: Phase shift starts on load bit falling edge.
// R4: Shift only outputs whose divide and delay differ.
// R5: Power bit low powers loop down; resets high.
// R6: Bus reset bit holds loop in reset.
// R7: Optional loop reset on reference switch.
// R8: Whole-loop reset port honoured only when enabled.
// R9: Main reset port honoured only when enabled.
// R10: Standby port acts only when enabled.
// R11: Secondary gating aligned to primary when enabled.
// R12: Second secondary reset port needs enable bit.
// R13: Host writes only offsets zero to eleven.
// R14: Host programs divider as ratio minus one.
// R15: Host sets delay equal to divider for zero shift.
// R16: Host writes load bit high then low.
`default_nettype none

module pcr_bank #(
    parameter int REFSW_RESET_CYCLES = pcr_pkg::REFSW_RESET_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wire pcr_pkg::pcr_wb_req_s wb_req,
    output var logic [pcr_pkg::DAT_W-1:0] wb_dat_q,
    output var logic wb_ack_q,
    // Loop pins
    input wire logic whole_reset_port,
    input wire logic main_reset_port,
    input wire logic second_secondary_reset_port,
    input wire logic standby_port,
    input wire logic reference_select_mux,
    input wire logic primary_output_clock,
    input wire logic [pcr_pkg::NUM_SEC-1:0] secondary_enable_req,
    // Same-clock configuration
    input wire logic dynamic_phase_select,
    // Loop control
    output var pcr_pkg::pcr_loop_ctrl_s loop_ctrl_q,
    output var logic [pcr_pkg::NUM_OUT-1:0] phase_shift_q,
    output var logic [pcr_pkg::NUM_SEC-1:0] secondary_enable_q
);

    localparam int CNT_W = $clog2(REFSW_RESET_CYCLES + 1);

    initial begin
        if (REFSW_RESET_CYCLES < 1 || REFSW_RESET_CYCLES > 65535) begin
            $error("REFSW_RESET_CYCLES out of range");
        end
    end

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    localparam int PIN_W = 6 + pcr_pkg::NUM_SEC;

    logic [PIN_W-1:0] pins_s;
    logic prim_prev_q;
    logic ref_prev_q;

    pcr_sync #(
        .W(PIN_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({secondary_enable_req, primary_output_clock, reference_select_mux,
            standby_port, second_secondary_reset_port, main_reset_port, whole_reset_port}),
        .sync_out(pins_s)
    );

    wire logic whole_s = pins_s[0];
    wire logic main_s = pins_s[1];
    wire logic sec2_s = pins_s[2];
    wire logic standby_port_s = pins_s[3];
    wire logic ref_s = pins_s[4];
    wire logic prim_s = pins_s[5];
    wire logic [pcr_pkg::NUM_SEC-1:0] sec_req_s = pins_s[PIN_W-1:6];
    wire logic primary_tick = prim_s && !prim_prev_q;
    wire logic ref_switched = ref_s != ref_prev_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prim_prev_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            prim_prev_q <= prim_s;
            ref_prev_q <= ref_s;
        end
    end

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic [7:0] frac_lo_q;
    logic [7:0] frac_hi_q;
    logic [pcr_pkg::NUM_CMD-1:0] cmd_q;
    logic [pcr_pkg::FIELD_W-1:0] field_q [pcr_pkg::NUM_FIELD];

    wire logic [4:0] adr = wb_req.adr;
    wire logic take = wb_req.cyc && wb_req.stb && !wb_ack_q;
    wire logic wr = take && wb_req.we;
    wire logic [4:0] slot = 5'(adr - pcr_pkg::OFS_CMD_FIRST);
    wire logic in_cmd = adr >= pcr_pkg::OFS_CMD_FIRST && adr <= pcr_pkg::OFS_CMD_LAST;
    wire logic in_field = adr >= pcr_pkg::OFS_DELAY_FIRST && adr <= pcr_pkg::OFS_FIELD_LAST;
    wire logic wr_lo = wr && adr == pcr_pkg::OFS_FRAC_LO;
    wire logic wr_hi = wr && adr == pcr_pkg::OFS_FRAC_HI;
    wire logic cmd_bit = in_cmd && cmd_q[slot[3:0]];
    wire logic [6:0] field_val = in_field ? field_q[slot[2:0]] : 7'h00;
    wire logic [7:0] rd_data =
        (adr == pcr_pkg::OFS_FRAC_LO) ? frac_lo_q :
        (adr == pcr_pkg::OFS_FRAC_HI) ? frac_hi_q :
        {cmd_bit, field_val};

    // Unmapped offsets are acknowledged, read zero and drop writes.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 8'h00;
        end else begin
            wb_ack_q <= take;
            wb_dat_q <= take ? rd_data : 8'h00;
        end
    end

    // ************************************************************
    // Register storage
    // ************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frac_lo_q <= pcr_pkg::RST_FRAC_BYTE;
            frac_hi_q <= pcr_pkg::RST_FRAC_BYTE;
        end else begin
            if (wr_lo) begin // [R1]
                frac_lo_q <= wb_req.dat;
            end
            if (wr_hi) begin // [R1]
                frac_hi_q <= wb_req.dat;
            end
        end
    end

    genvar c;
    generate
        for (c = 0; c < pcr_pkg::NUM_CMD; c++) begin : gen_cmd
            wire logic hit = wr && in_cmd && slot == 5'(c);
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cmd_q[c] <= pcr_pkg::RST_CMD[c];
                end else if (hit) begin
                    cmd_q[c] <= wb_req.dat[pcr_pkg::CMD_BIT];
                end
            end
        end
        for (c = 0; c < pcr_pkg::NUM_FIELD; c++) begin : gen_field
            wire logic hit = wr && in_field && slot == 5'(c);
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    field_q[c] <= pcr_pkg::RST_FIELD;
                end else if (hit) begin
                    field_q[c] <= wb_req.dat[pcr_pkg::FIELD_W-1:0];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Phase load command
    // ************************************************************
    logic load_prev_q;
    logic [pcr_pkg::NUM_OUT-1:0] differs;

    // Delay fields occupy slots 0..3, divide fields slots 4..7.
    generate
        for (c = 0; c < pcr_pkg::NUM_OUT; c++) begin : gen_diff
            assign differs[c] = field_q[c] != field_q[c + pcr_pkg::NUM_OUT]; // [R4]
        end
    endgenerate

    wire logic load_fell = load_prev_q && !cmd_q[pcr_pkg::CI_LOAD]; // [R3]
    wire logic load_go = load_fell && !dynamic_phase_select; // [R3]

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            load_prev_q <= 1'b0;
            phase_shift_q <= '0;
        end else begin
            load_prev_q <= cmd_q[pcr_pkg::CI_LOAD];
            phase_shift_q <= load_go ? differs : '0; // [R4]
        end
    end

    // ************************************************************
    // Reference switch reset
    // ************************************************************
    logic [CNT_W-1:0] refsw_cnt_q;

    // The reset is stretched so the loop sees a clean pulse, not one cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            refsw_cnt_q <= '0;
        end else if (ref_switched && cmd_q[pcr_pkg::CI_REFSW]) begin // [R7]
            refsw_cnt_q <= CNT_W'(REFSW_RESET_CYCLES);
        end else if (refsw_cnt_q != '0) begin
            refsw_cnt_q <= refsw_cnt_q - 1'b1;
        end
    end

    // ************************************************************
    // Loop control outputs
    // ************************************************************
    pcr_pkg::pcr_loop_ctrl_s ctrl_d;

    wire logic main_hit = main_s && cmd_q[pcr_pkg::CI_MAIN]; // [R9]
    wire logic refsw_active = refsw_cnt_q != '0;
    wire logic standby_port_hit = standby_port_s && cmd_q[pcr_pkg::CI_STANDBY_PORT]; // [R10]

    assign ctrl_d.power_down = !cmd_q[pcr_pkg::CI_POWER] || standby_port_hit; // [R5]
    assign ctrl_d.loop_reset = cmd_q[pcr_pkg::CI_BUSRST] || main_hit || refsw_active; // [R6]
    assign ctrl_d.whole_reset = whole_s && cmd_q[pcr_pkg::CI_WHOLE]; // [R8]
    assign ctrl_d.sec2_reset = sec2_s && cmd_q[pcr_pkg::CI_SEC2]; // [R12]
    assign ctrl_d.frac_enable = cmd_q[pcr_pkg::CI_FRAC]; // [R2]
    // Ratio is this value over 65535; the analog divider does the division.
    assign ctrl_d.frac_value = {frac_hi_q, frac_lo_q}; // [R1]

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loop_ctrl_q <= '{power_down: 1'b0, loop_reset: 1'b0, whole_reset: 1'b0,
                sec2_reset: 1'b0, frac_enable: 1'b0, frac_value: 16'h0000};
        end else begin
            loop_ctrl_q <= ctrl_d;
        end
    end

    pcr_gate #(
        .N(pcr_pkg::NUM_SEC)
    ) u_gate (
        .clk(clk),
        .resetn(resetn),
        .sync_en(cmd_q[pcr_pkg::CI_SYNC]),
        .primary_tick(primary_tick),
        .enable_req(sec_req_s),
        .enable_q(secondary_enable_q)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    AST_FRAC_LOW_BYTE: assert property ( // [R1]
        @(posedge clk) disable iff (!resetn)
        wr_lo |-> ##2 loop_ctrl_q.frac_value[7:0] == $past(wb_req.dat, 2))
        else $error("low fraction byte not delivered");

    AST_FRAC_MODE: assert property ( // [R2]
        @(posedge clk) disable iff (!resetn)
        (wr && adr == 5'h05) |-> ##2 loop_ctrl_q.frac_enable == $past(wb_req.dat[7], 2))
        else $error("fractional mode does not follow its bit");

    AST_LOAD_EDGE: assert property ( // [R3]
        @(posedge clk) disable iff (!resetn)
        (phase_shift_q != '0) |-> $past(cmd_q[pcr_pkg::CI_LOAD], 2)
            && !$past(cmd_q[pcr_pkg::CI_LOAD]) && !$past(dynamic_phase_select))
        else $error("phase shift without a load falling edge");

    AST_SHIFT_MASK: assert property ( // [R4]
        @(posedge clk) disable iff (!resetn)
        load_go |=> phase_shift_q == $past(differs))
        else $error("phase shift mask wrong");

    AST_POWER_DOWN: assert property ( // [R5]
        @(posedge clk) disable iff (!resetn)
        (cmd_q[pcr_pkg::CI_POWER] && !standby_port_hit) |=> !loop_ctrl_q.power_down)
        else $error("loop powered down while power bit set");

    AST_BUS_RESET: assert property ( // [R6]
        @(posedge clk) disable iff (!resetn)
        cmd_q[pcr_pkg::CI_BUSRST] |=> loop_ctrl_q.loop_reset)
        else $error("bus reset not applied");

    AST_REFSW_RESET: assert property ( // [R7]
        @(posedge clk) disable iff (!resetn)
        (ref_switched && cmd_q[pcr_pkg::CI_REFSW]) |=> ##1 loop_ctrl_q.loop_reset)
        else $error("reference switch did not reset loop");

    AST_WHOLE_GATED: assert property ( // [R8]
        @(posedge clk) disable iff (!resetn)
        !cmd_q[pcr_pkg::CI_WHOLE] |=> !loop_ctrl_q.whole_reset)
        else $error("whole reset passed while disabled");

    AST_MAIN_GATED: assert property ( // [R9]
        @(posedge clk) disable iff (!resetn)
        (!cmd_q[pcr_pkg::CI_MAIN] && !cmd_q[pcr_pkg::CI_BUSRST] && !refsw_active)
            |=> !loop_ctrl_q.loop_reset)
        else $error("main reset passed while disabled");

    AST_STANDBY: assert property ( // [R10]
        @(posedge clk) disable iff (!resetn)
        (standby_port_s && cmd_q[pcr_pkg::CI_STANDBY_PORT]) |=> loop_ctrl_q.power_down)
        else $error("enabled standby ignored");

    AST_SEC2_GATED: assert property ( // [R12]
        @(posedge clk) disable iff (!resetn)
        loop_ctrl_q.sec2_reset |-> $past(cmd_q[pcr_pkg::CI_SEC2]) && $past(sec2_s))
        else $error("secondary reset passed while disabled");

endmodule

`default_nettype wire

/* pcr_pkg.sv */
// Shared constants and carrier types for the loop configuration register bank.
`default_nettype none

package pcr_pkg;

    // ************************************************************
    // Bus geometry and register offsets
    // ************************************************************
    localparam int ADR_W = 5;
    localparam int DAT_W = 8;
    localparam logic [4:0] OFS_FRAC_LO = 5'h00;
    localparam logic [4:0] OFS_FRAC_HI = 5'h01;
    localparam logic [4:0] OFS_CMD_FIRST = 5'h02;
    localparam logic [4:0] OFS_CMD_LAST = 5'h0b;
    localparam logic [4:0] OFS_DELAY_FIRST = 5'h02;
    localparam logic [4:0] OFS_DIVIDE_FIRST = 5'h06;
    localparam logic [4:0] OFS_FIELD_LAST = 5'h09;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CMD_BIT = 7;
    localparam int FIELD_W = 7;
    localparam int NUM_CMD = 10;
    localparam int NUM_FIELD = 8;
    localparam int NUM_OUT = 4;
    localparam int NUM_SEC = 3;
    // Command bit index equals register offset minus two.
    localparam int CI_LOAD = 0;
    localparam int CI_POWER = 1;
    localparam int CI_BUSRST = 2;
    localparam int CI_FRAC = 3;
    localparam int CI_REFSW = 4;
    localparam int CI_WHOLE = 5;
    localparam int CI_MAIN = 6;
    localparam int CI_STANDBY_PORT = 7;
    localparam int CI_SYNC = 8;
    localparam int CI_SEC2 = 9;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [9:0] RST_CMD = 10'h002;
    localparam logic [6:0] RST_FIELD = 7'h07;
    localparam logic [7:0] RST_FRAC_BYTE = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int REFSW_RESET_NS = 1000;
    localparam int REFSW_RESET_CYC = (REFSW_RESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
    } pcr_wb_req_s;

    typedef struct packed {
        logic power_down;
        logic loop_reset;
        logic whole_reset;
        logic sec2_reset;
        logic frac_enable;
        logic [15:0] frac_value;
    } pcr_loop_ctrl_s;

endpackage

`default_nettype wire

/* pcr_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
`default_nettype none

module pcr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Levels
    input wire logic [W-1:0] async_in,
    output var logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) begin
            $error("pcr_sync needs at least one bit");
        end
    end

    // The first stage feeds only the second one.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

/* pcr_gate.sv */
// Enable gating of the secondary outputs, optionally aligned to the primary output.
`default_nettype none

module pcr_gate #(
    parameter int N = pcr_pkg::NUM_SEC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic sync_en,
    input wire logic primary_tick,
    input wire logic [N-1:0] enable_req,
    // Gated enables
    output var logic [N-1:0] enable_q
);

    initial begin
        if (N < 1) begin
            $error("pcr_gate needs at least one output");
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_gate
            wire logic take = !sync_en || primary_tick;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    enable_q[g] <= 1'b0;
                end else if (take) begin // [R11]
                    enable_q[g] <= enable_req[g];
                end
            end
        end
    endgenerate

    // In aligned mode an enable only moves on a primary output edge.
    AST_SYNC_GATE: assert property ( // [R11]
        @(posedge clk) disable iff (!resetn)
        (sync_en && !primary_tick) |=> $stable(enable_q))
        else $error("secondary enable moved between primary edges");

endmodule

`default_nettype wire

/* pcr_host.sv */
// Wishbone host model that programs the loop configuration register bank.
`default_nettype none

module pcr_host (
    // Clock
    input wire logic clk,
    // Bus
    output var pcr_pkg::pcr_wb_req_s wb_req,
    input wire logic [7:0] wb_dat_q,
    input wire logic wb_ack_q
);
    timeunit 1ns;
    timeprecision 1ps;

    int fails = 0;

    initial wb_req = '0;

    // ************************************************************
    // Bus cycles
    // ************************************************************
    // The request stands until ack is sampled or eight cycles pass; released lines show the inverse of the
    // last value so that a stale address or data byte can never pass for a live one.
    task automatic access(input logic we, input logic [4:0] adr, input logic [7:0] dat,
                          output logic [7:0] rdat);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: dat};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_q !== 1'b1 && n < 8);
        if (wb_ack_q !== 1'b1) begin
            fails++;
        end
        rdat = wb_dat_q;
        wb_req <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, adr: ~adr, dat: ~dat};
    endtask

    // Writes are refused above the user range, so no reserved place is disturbed.
    task automatic wr(input logic [4:0] adr, input logic [7:0] dat);
        logic [7:0] x;
        if (adr > 5'h0b) begin
            fails++;
        end else begin
            access(1'b1, adr, dat, x);
        end
    endtask

    task automatic rd(input logic [4:0] adr, output logic [7:0] dat);
        access(1'b0, adr, 8'h00, dat);
    endtask

    // The shift starts only when the bit goes back down, so raise it and then drop it.
    task automatic pulse_load(input logic [6:0] delay0);
        wr(5'h02, {1'b1, delay0});
        wr(5'h02, {1'b0, delay0});
    endtask
endmodule

`default_nettype wire

/* pll_config_register_bank_bench.sv */
// Self-checking testbench of the loop configuration register bank.
`default_nettype none

module pll_config_register_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int REFSW = 3;
    localparam logic [4:0] EN_OFS [4] = '{5'h07, 5'h08, 5'h0b, 5'h09};
    localparam int FLAG_BIT [4] = '{2, 3, 1, 4};

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] pins = 4'h0;
    logic ref_sel = 1'b0;
    logic prim = 1'b0;
    logic [2:0] sec_req = 3'h0;
    logic dyn = 1'b0;
    pcr_pkg::pcr_wb_req_s wb_req;
    logic [7:0] wb_dat_q;
    logic wb_ack_q;
    pcr_pkg::pcr_loop_ctrl_s lc;
    logic [3:0] ps;
    logic [2:0] sec_en;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    pcr_bank #(.REFSW_RESET_CYCLES(REFSW)) dut (
        .clk(clk),
        .resetn(resetn),
        .wb_req(wb_req),
        .wb_dat_q(wb_dat_q),
        .wb_ack_q(wb_ack_q),
        .whole_reset_port(pins[0]),
        .main_reset_port(pins[1]),
        .second_secondary_reset_port(pins[2]),
        .standby_port(pins[3]),
        .reference_select_mux(ref_sel),
        .primary_output_clock(prim),
        .secondary_enable_req(sec_req),
        .dynamic_phase_select(dyn),
        .loop_ctrl_q(lc),
        .phase_shift_q(ps),
        .secondary_enable_q(sec_en)
    );

    pcr_host host (
        .clk(clk),
        .wb_req(wb_req),
        .wb_dat_q(wb_dat_q),
        .wb_ack_q(wb_ack_q)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [15:0] flags();
        return {11'h0, lc.power_down, lc.loop_reset, lc.whole_reset, lc.sec2_reset,
                lc.frac_enable};
    endfunction

    task automatic watch(input logic [3:0] exp);
        @(posedge clk);
        check("phase pulse", {12'h0, ps}, {12'h0, exp});
        repeat (3) begin
            @(posedge clk);
            check("phase idle", {12'h0, ps}, 16'h0000);
        end
    endtask

    task automatic finish_test();
        bad_count += host.fails;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        logic [7:0] r;
        logic [15:0] want;
        settle(2);
        check("flags after reset", flags(), 16'h0000);
        for (int a = 0; a < 14; a++) begin
            host.rd((a == 13) ? 5'h1f : 5'(a), r);
            want = (a < 2 || a > 9) ? 16'h0000 : ((a == 3) ? 16'h0087 : 16'h0007);
            check("reset read", {8'h00, r}, want);
        end
    endtask

    task automatic t_bus_power();
        host.wr(5'h03, 8'h07);
        settle(2);
        check("power bit low", flags(), 16'h0010);
        host.wr(5'h03, 8'h87);
        host.wr(5'h04, 8'h87);
        settle(2);
        check("bus reset on", flags(), 16'h0008);
        host.wr(5'h04, 8'h07);
        settle(2);
        check("bus reset off", flags(), 16'h0000);
    endtask

    task automatic t_frac();
        logic [7:0] r;
        host.wr(5'h00, 8'h34);
        host.wr(5'h01, 8'hcb);
        settle(2);
        check("fraction", lc.frac_value, 16'hcb34);
        check("mode off", flags(), 16'h0000);
        host.wr(5'h05, 8'h87);
        settle(2);
        check("mode on", flags(), 16'h0001);
        host.wr(5'h05, 8'h07);
        host.rd(5'h01, r);
        check("fraction high read", {8'h00, r}, 16'h00cb);
    endtask

    // Each enable bit gates its own pin; the pin is raised first with the enable still off.
    task automatic t_port(input int i);
        logic [7:0] lo;
        lo = (i == 2) ? 8'h00 : 8'h07;
        @(posedge clk);
        pins[i] <= 1'b1;
        settle(5);
        check("port disabled", flags(), 16'h0000);
        host.wr(EN_OFS[i], lo | 8'h80);
        settle(2);
        check("port enabled", flags(), 16'h0001 << FLAG_BIT[i]);
        @(posedge clk);
        pins[i] <= 1'b0;
        settle(5);
        check("port released", flags(), 16'h0000);
        host.wr(EN_OFS[i], lo);
    endtask

    task automatic t_phase();
        // Dividers keep ratio eight minus one; delays differ on outputs one, three.
        host.wr(5'h03, 8'h85);
        host.wr(5'h05, 8'h02);
        host.wr(5'h02, 8'h87);
        watch(4'h0);
        host.wr(5'h02, 8'h07);
        watch(4'ha);
        host.wr(5'h02, 8'h07);
        watch(4'h0);
        @(posedge clk);
        dyn <= 1'b1;
        host.pulse_load(7'h07);
        watch(4'h0);
        @(posedge clk);
        dyn <= 1'b0;
        host.wr(5'h03, 8'h87);
        host.wr(5'h05, 8'h07);
    endtask

    task automatic t_refsw(input logic [7:0] v, input int exp);
        int n;
        n = 0;
        host.wr(5'h06, v);
        @(posedge clk);
        ref_sel <= ~ref_sel;
        repeat (16) begin
            @(posedge clk);
            if (lc.loop_reset === 1'b1) begin
                n++;
            end
        end
        check("refswitch reset length", 16'(n), 16'(exp));
    endtask

    task automatic t_gate();
        @(posedge clk);
        sec_req <= 3'h5;
        settle(4);
        check("gating free", {13'h0, sec_en}, 16'h0005);
        host.wr(5'h0a, 8'h80);
        @(posedge clk);
        sec_req <= 3'h2;
        settle(6);
        check("gating held", {13'h0, sec_en}, 16'h0005);
        @(posedge clk);
        prim <= 1'b1;
        settle(5);
        check("gating aligned", {13'h0, sec_en}, 16'h0002);
        @(posedge clk);
        prim <= 1'b0;
        host.wr(5'h0a, 8'h00);
    endtask

    // A hung handshake only costs eight cycles per access; the ceiling is several times the run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_bus_power();
        t_frac();
        for (int i = 0; i < 4; i++) begin
            t_port(i);
        end
        t_phase();
        t_refsw(8'h07, 0);
        t_refsw(8'h87, REFSW);
        host.wr(5'h06, 8'h07);
        t_gate();
        finish_test();
    end
endmodule

`default_nettype wire
